// ===== logic/tsec_defs.vh
// constants shared by the two-stage event controller files
`ifndef TSEC_DEFS_VH
`define TSEC_DEFS_VH

// ----------------------------------------------------------------
// register byte offsets (apb, one aligned word each)
// ----------------------------------------------------------------
`define TSEC_OFF_CMASK   8'h00
`define TSEC_OFF_LATCH   8'h04
`define TSEC_OFF_PEND    8'h08
`define TSEC_OFF_PMASK   8'h0C
`define TSEC_OFF_PSTAT   8'h10
`define TSEC_OFF_PWAKE   8'h14
`define TSEC_OFF_IAR0    8'h18
`define TSEC_OFF_IAR1    8'h1C
`define TSEC_OFF_IAR2    8'h20
`define TSEC_OFF_IAR3    8'h24
`define TSEC_OFF_CTRL    8'h28
`define TSEC_OFF_SWRAISE 8'h2C
`define TSEC_OFF_ISTAT   8'h30
`define TSEC_OFF_CORE_MASK_BITS   8'h34

// ----------------------------------------------------------------
// core event levels, 0 is the highest priority
// ----------------------------------------------------------------
`define TSEC_LVL_EMU  4'h0
`define TSEC_LVL_RST  4'h1
`define TSEC_LVL_NMI  4'h2
`define TSEC_LVL_EVX  4'h3
`define TSEC_LVL_RSV  4'h4
`define TSEC_LVL_HWE  4'h5
`define TSEC_LVL_TMR  4'h6
`define TSEC_LVL_GEN0 4'h7
`define TSEC_NGEN     4'h9

// ----------------------------------------------------------------
// fixed masks and reset values
// ----------------------------------------------------------------
`define TSEC_NOMASK_LVLS 16'h000F
`define TSEC_RSV_LVLS    16'h0010
`define TSEC_GEN_LVLS    16'hFF80
`define TSEC_CMASK_RST   16'h000F
`define TSEC_IAR0_RST    32'h22211000
`define TSEC_IAR1_RST    32'h43333332
`define TSEC_IAR2_RST    32'h55555444
`define TSEC_IAR3_RST    32'h66655555

// ----------------------------------------------------------------
// sticky interrupt status bits
// ----------------------------------------------------------------
`define TSEC_IRQ_WAKE 0
`define TSEC_IRQ_NMI  1
`define TSEC_IRQ_HWE  2
`define TSEC_IRQ_W    3

`endif

// ===== logic/tsec_sync.v
// three-flop synchroniser with agreement filter and rise pulse
`timescale 1ns/10ps
`default_nettype none

module tsec_sync #(
  parameter W = 32                 // number of lines
) (
  // clock and reset
  input  wire         pclk,
  input  wire         presetn,
  // asynchronous lines in
  input  wire [W-1:0] async_in,
  // filtered level and one-cycle rise
  output reg  [W-1:0] level,
  output reg  [W-1:0] rise
);

  reg [W-1:0] s1;                  // metastable stage, read by s2 only
  reg [W-1:0] s2;                  // second stage
  reg [W-1:0] s3;                  // third stage

  // ----------------------------------------------------------------
  // chain; a change counts once the second and third stages agree
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1    <= {W{1'b0}};
      s2    <= {W{1'b0}};
      s3    <= {W{1'b0}};
      level <= {W{1'b0}};
      rise  <= {W{1'b0}};
    end else begin
      s1    <= async_in;
      s2    <= s1;
      s3    <= s2;
      // only lines where s2 and s3 agree take the new value
      level <= (s2 & s3) | (level & (s2 ^ s3));
      rise  <= (s2 & s3) & ~level;
    end
  end

endmodule

`default_nettype wire

// ===== logic/tsec_top.v
// two-stage event controller: system stage, core stage, apb registers
//
// Chosen here: the APB interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "tsec_defs.vh"

module tsec_top #(
  parameter NPER = 32,             // peripheral request lines
  parameter AW   = 32              // return address width
) (
  // apb clock and reset
  input  wire            pclk,
  input  wire            presetn,
  // apb slave
  input  wire            psel,
  input  wire            penable,
  input  wire            pwrite,
  input  wire [7:0]      paddr,
  input  wire [31:0]     pwdata,
  output reg  [31:0]     prdata,
  output wire            pready,
  output wire            pslverr,
  // asynchronous event sources
  input  wire [NPER-1:0] periph_irq,
  input  wire            nmi_pin,
  input  wire            wdog_nmi,
  input  wire            emu_req,
  input  wire            rst_req,
  // same-clock core sources
  input  wire            exc_req,
  input  wire            hwerr_req,
  input  wire            ctimer_req,
  input  wire            core_idle,
  // sequencer handshake
  output reg             evt_valid,
  output reg  [3:0]      evt_level,
  input  wire            evt_accept,
  input  wire [AW-1:0]   evt_pc,
  input  wire            evt_return,
  input  wire [3:0]      ret_level,
  output reg  [AW-1:0]   ret_addr,
  output reg             save_state,
  output reg             emul_mode,
  output reg             core_reset,
  // system outputs
  output wire            wake_out,
  output wire            irq
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // lowest set index wins; all-zero gives 4'hF (caller checks any)
  function [3:0] tsec_first;
    input [15:0] v;
    integer i;
    begin
      tsec_first = 4'hF;
      for (i = 15; i >= 0; i = i - 1)
        if (v[i])
          tsec_first = i[3:0];
    end
  endfunction

  // general-input number (0..8) that peripheral line n is routed to
  function [3:0] tsec_route;
    input [127:0] interrupt_assignment_regs;
    input integer n;
    begin
      tsec_route = interrupt_assignment_regs[n*4 +: 4];
    end
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg  [15:0]     cmask;           // core mask bits
  reg  [15:0]     latch;           // event latch bits
  reg  [15:0]     pend;            // event pending bits (nest stack)
  reg  [31:0]     pmask;           // peripheral mask bits
  reg  [31:0]     pwake;           // peripheral wakeup bits
  reg  [127:0]    interrupt_assignment_regs;             // assignment regs, nibble per line
  reg             gen_en;          // global enable of general levels
  reg  [`TSEC_IRQ_W-1:0] istat;    // sticky interrupt status
  reg  [`TSEC_IRQ_W-1:0] core_mask_bits;    // interrupt mask
  reg  [8:0]      gen_d;           // general inputs one cycle ago
  reg  [2:0]      edge_d;          // core source levels one cycle ago
  reg  [AW-1:0]   ret_mem [0:15];  // return address per level
  reg  [15:0]     next_latch;
  reg  [15:0]     next_pend;
  reg  [8:0]      gen_in;          // combined per general input
  integer         k;

  wire [NPER-1:0] pstat;           // synchronised peripheral level
  wire [3:0]      asy_lvl;         // synchronised emu/rst/nmi lines
  wire [3:0]      asy_rise;

  // ----------------------------------------------------------------
  // synchronisers for pins and peripheral lines
  // ----------------------------------------------------------------
  // peripheral lines need only the filtered level; edges are found
  // later, per general input, after masking and routing
  tsec_sync #(.W(NPER)) u_psync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (periph_irq),
    .level    (pstat),
    .rise     ()
  );

  tsec_sync #(.W(4)) u_csync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({wdog_nmi, nmi_pin, rst_req, emu_req}),
    .level    (asy_lvl),
    .rise     (asy_rise)
  );

  // ----------------------------------------------------------------
  // system stage: mask and route each line to a general input
  // ----------------------------------------------------------------
  // lines sharing one input merge into one level, so a second line
  // rising while the first still stands gives no new edge
  always @* begin
    gen_in = 9'h000;
    for (k = 0; k < NPER; k = k + 1)
      if (pstat[k] & pmask[k] & (tsec_route(interrupt_assignment_regs, k) < `TSEC_NGEN))
        gen_in[tsec_route(interrupt_assignment_regs, k)] = 1'b1;
  end

  // wake the idle core for any enabled asserting line
  assign wake_out = core_idle & |(pstat & pwake);

  // ----------------------------------------------------------------
  // core stage: edge detect and arbitration
  // ----------------------------------------------------------------
  // nine general inputs feed levels 7 to 15 in order
  wire [8:0]  gen_rise = gen_in & ~gen_d;
  wire        nmi_rise = asy_rise[2] | asy_rise[3];
  wire        exc_rise = exc_req & ~edge_d[0];
  wire        hwe_rise = hwerr_req & ~edge_d[1];
  wire        tmr_rise = ctimer_req & ~edge_d[2];

  // hardware sets per level, seven classes on sixteen levels
  wire [15:0] hw_set = {gen_rise, tmr_rise, hwe_rise, 1'b0,
                        exc_rise, nmi_rise, asy_rise[1],
                        asy_rise[0]};

  // levels 0..3 cannot be masked, reserved level never served
  // clearing the global enable parks general levels in the latch
  wire [15:0] allow = (cmask | `TSEC_NOMASK_LVLS) & ~`TSEC_RSV_LVLS &
                      (gen_en ? 16'hFFFF : ~`TSEC_GEN_LVLS);

  // only levels strictly above the active routine may nest in
  wire [3:0]  act_lvl = tsec_first(pend);
  wire [15:0] above   = (|pend) ? ((16'h0001 << act_lvl) - 16'h0001)
                                : 16'hFFFF;
  // an offer not yet taken is re-evaluated each cycle, so a newly
  // latched higher level replaces it rather than waiting behind it
  wire [15:0] elig    = latch & allow & above;
  wire        take    = evt_valid & evt_accept;

  // ----------------------------------------------------------------
  // apb decode; read data is captured in the setup cycle
  // ----------------------------------------------------------------
  wire setup  = psel & ~penable;
  wire wr_acc = psel & penable & pwrite;
  reg  hit;                                          // address mapped
  reg  [31:0] rd_mux;

  // every register is a flop or a mux of flops, so no wait is needed
  assign pready  = 1'b1;           // zero wait states
  assign pslverr = psel & penable & ~hit;

  always @* begin
    hit    = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      `TSEC_OFF_CMASK:   rd_mux = {16'h0000, cmask};
      `TSEC_OFF_LATCH:   rd_mux = {16'h0000, latch};
      `TSEC_OFF_PEND:    rd_mux = {16'h0000, pend};
      `TSEC_OFF_PMASK:   rd_mux = pmask;
      `TSEC_OFF_PSTAT:   rd_mux = pstat & pmask;
      `TSEC_OFF_PWAKE:   rd_mux = pwake;
      `TSEC_OFF_IAR0:    rd_mux = interrupt_assignment_regs[31:0];
      `TSEC_OFF_IAR1:    rd_mux = interrupt_assignment_regs[63:32];
      `TSEC_OFF_IAR2:    rd_mux = interrupt_assignment_regs[95:64];
      `TSEC_OFF_IAR3:    rd_mux = interrupt_assignment_regs[127:96];
      `TSEC_OFF_CTRL:    rd_mux = {31'h0000_0000, gen_en};
      `TSEC_OFF_SWRAISE: rd_mux = 32'h0000_0000;
      `TSEC_OFF_ISTAT:   rd_mux = {29'h0000_0000, istat};
      `TSEC_OFF_CORE_MASK_BITS:   rd_mux = {29'h0000_0000, core_mask_bits};
      default:           hit = 1'b0;                // unmapped: error
    endcase
  end

  // ----------------------------------------------------------------
  // next latch and pending values
  // ----------------------------------------------------------------
  always @* begin
    // clear, take and soft raise first, hardware set last so it wins
    next_latch = latch;
    next_pend  = pend;
    // software clears latch bits only while their mask bit is clear
    if (wr_acc && paddr == `TSEC_OFF_LATCH)
      next_latch = next_latch & ~(pwdata[15:0] & ~cmask);
    // accepted level leaves the latch and enters the nest
    if (take) begin
      next_latch[evt_level] = 1'b0;
      next_pend[evt_level]  = 1'b1;
    end
    // return-from-event of a level closes its nest entry
    if (evt_return)
      next_pend[ret_level] = 1'b0;
    // software raise of general levels, the soft instruction path
    if (wr_acc && paddr == `TSEC_OFF_SWRAISE)
      next_latch = next_latch | (pwdata[15:0] & `TSEC_GEN_LVLS);
    // a new edge wins over a clear in the same cycle
    next_latch = next_latch | hw_set;
  end

  // ----------------------------------------------------------------
  // core stage registers and offer to the sequencer
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch      <= 16'h0000;
      pend       <= 16'h0000;
      gen_d      <= 9'h000;
      edge_d     <= 3'h0;
      evt_valid  <= 1'b0;
      evt_level  <= 4'h0;
      save_state <= 1'b0;
      emul_mode  <= 1'b0;
      core_reset <= 1'b0;
      ret_addr   <= {AW{1'b0}};
    end else begin
      latch  <= next_latch;
      pend   <= next_pend;
      gen_d  <= gen_in;
      edge_d <= {ctimer_req, hwerr_req, exc_req};
      // winner is the highest eligible level; offer drops after a take
      evt_valid <= (|elig) & ~take;
      // level is recomputed every cycle; only valid gives it meaning
      evt_level <= tsec_first(elig);
      // processor state goes to the supervisor stack on every entry
      save_state <= take;
      // reset event pulses the core reset, ranked just below emulation
      core_reset <= take && evt_level == `TSEC_LVL_RST;
      // emulation entry and exit
      // a take of level zero wins over a return in the same cycle
      if (take && evt_level == `TSEC_LVL_EMU)
        emul_mode <= 1'b1;
      else if (evt_return && ret_level == `TSEC_LVL_EMU)
        emul_mode <= 1'b0;
      // each level hands back its own return address
      if (evt_return)
        ret_addr <= ret_mem[ret_level];
    end
  end

  // return address store, no reset needed for the data array
  // an entry is read only after a take of its level has written it
  always @(posedge pclk) begin
    if (take)
      ret_mem[evt_level] <= evt_pc;
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmask  <= `TSEC_CMASK_RST;
      pmask  <= 32'h0000_0000;
      pwake  <= 32'h0000_0000;
      interrupt_assignment_regs    <= {`TSEC_IAR3_RST, `TSEC_IAR2_RST,
                 `TSEC_IAR1_RST, `TSEC_IAR0_RST};
      gen_en <= 1'b1;
      core_mask_bits  <= {`TSEC_IRQ_W{1'b0}};
      prdata <= 32'h0000_0000;
    end else begin
      if (setup)
        prdata <= rd_mux;
      if (wr_acc) begin
        case (paddr)
          `TSEC_OFF_CMASK: cmask <= pwdata[15:0] | `TSEC_NOMASK_LVLS;
          `TSEC_OFF_PMASK: pmask <= pwdata;
          `TSEC_OFF_PWAKE: pwake <= pwdata;
          `TSEC_OFF_IAR0:  interrupt_assignment_regs[31:0]   <= pwdata;
          `TSEC_OFF_IAR1:  interrupt_assignment_regs[63:32]  <= pwdata;
          `TSEC_OFF_IAR2:  interrupt_assignment_regs[95:64]  <= pwdata;
          `TSEC_OFF_IAR3:  interrupt_assignment_regs[127:96] <= pwdata;
          `TSEC_OFF_CTRL:  gen_en <= pwdata[0];
          `TSEC_OFF_CORE_MASK_BITS: core_mask_bits  <= pwdata[`TSEC_IRQ_W-1:0];
          default: ;                                // latch, swraise and istat handled elsewhere; pend and pstat writes ignored
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // sticky interrupt status, write one to clear, set wins
  // ----------------------------------------------------------------
  // bit order: hardware error edge, nmi taken, wakeup
  wire [`TSEC_IRQ_W-1:0] ev_set = {hwe_rise,
                                   take && evt_level == `TSEC_LVL_NMI,
                                   wake_out};
  wire [`TSEC_IRQ_W-1:0] ev_clr = (wr_acc && paddr == `TSEC_OFF_ISTAT) ?
                                  pwdata[`TSEC_IRQ_W-1:0] :
                                  {`TSEC_IRQ_W{1'b0}};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      istat <= {`TSEC_IRQ_W{1'b0}};
    else
      istat <= (istat & ~ev_clr) | ev_set;
  end

  // level output while any unmasked status bit stands
  // masking hides a bit from irq without clearing it
  assign irq = |(istat & core_mask_bits);

endmodule

`default_nettype wire

// ===== tb/tsec_seq_model.sv
// sequencer model that takes offered events and hands over a pc
`timescale 1ns/10ps
`default_nettype none

module tsec_seq_model (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // offer from the controller
  input  wire logic        evt_valid,
  input  wire logic [3:0]  evt_level,
  input  wire logic        slow,
  // take and pc
  output logic             evt_accept,
  output logic [31:0]      evt_pc
);
  logic [31:0] mem [16];  // pc handed over at each take, per level
  logic        go;        // random go-ahead when stalling

  // prompt mode keeps accept high so the shortest latency shows
  assign evt_accept = slow ? go : 1'b1;

  // pc moves every cycle so each take stores a distinct address
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_pc <= 32'h00001000;
      go     <= 1'b0;
    end else begin
      evt_pc <= evt_pc + 32'h4;
      go     <= ($urandom % 3) == 0;
      if (evt_valid && evt_accept) begin
        mem[evt_level] <= evt_pc;
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb/tsec_top_chk.sv
// port assertions for the two-stage event controller
`timescale 1ns/10ps
`default_nettype none
`include "tsec_defs.vh"

module tsec_top_chk (
  // clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // apb
  input wire logic       psel,
  input wire logic       penable,
  input wire logic [7:0] paddr,
  input wire logic       pslverr,
  // wakeup
  input wire logic       core_idle,
  input wire logic       wake_out,
  // sequencer
  input wire logic       evt_valid,
  input wire logic [3:0] evt_level,
  input wire logic       evt_accept,
  input wire logic       evt_return,
  input wire logic [3:0] ret_level,
  input wire logic       save_state,
  input wire logic       emul_mode,
  input wire logic       core_reset
);
  // ----------
  // helpers
  // ----------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire take = evt_valid && evt_accept;  // offer taken at this edge
  wire acc  = psel && penable;          // apb access phase

  // ----------
  // properties
  // ----------
  property p_no_rsv; evt_valid |-> evt_level != `TSEC_LVL_RSV; endproperty
  a_no_rsv: assert property (p_no_rsv) else $error("reserved level offered");
  property p_hold; evt_valid && !evt_accept |=> evt_valid && $stable(evt_level); endproperty
  a_hold: assert property (p_hold) else $error("offer changed before take");
  property p_gap; take |=> !evt_valid; endproperty
  a_gap: assert property (p_gap) else $error("offer not withdrawn after take");
  property p_save; take |=> save_state ##1 !save_state; endproperty
  a_save: assert property (p_save) else $error("state save pulse wrong");
  property p_emu; take && evt_level == `TSEC_LVL_EMU |=> emul_mode; endproperty
  a_emu: assert property (p_emu) else $error("emulation mode not entered");
  property p_emu_off; evt_return && ret_level == `TSEC_LVL_EMU && !take |=> !emul_mode; endproperty
  a_emu_off: assert property (p_emu_off) else $error("emulation mode kept");
  property p_rst; take && evt_level == `TSEC_LVL_RST |=> core_reset ##1 !core_reset; endproperty
  a_rst: assert property (p_rst) else $error("core reset pulse wrong");
  property p_rst_only; $rose(core_reset) |-> $past(take) && $past(evt_level) == `TSEC_LVL_RST; endproperty
  a_rst_only: assert property (p_rst_only) else $error("stray core reset");
  property p_wake; wake_out |-> core_idle; endproperty
  a_wake: assert property (p_wake) else $error("wakeup while core awake");
  property p_unmapped; acc && paddr > `TSEC_OFF_CORE_MASK_BITS |-> pslverr; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

  // main scenarios seen
  c_emu: cover property (take && evt_level == `TSEC_LVL_EMU);
  c_nest: cover property (take && evt_level == `TSEC_LVL_EVX);
  c_gen: cover property (take && evt_level == 4'hF);
  c_err: cover property (acc && pslverr);
endmodule

bind tsec_top tsec_top_chk i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr), .pslverr(pslverr),
  .core_idle(core_idle), .wake_out(wake_out), .evt_valid(evt_valid), .evt_level(evt_level),
  .evt_accept(evt_accept), .evt_return(evt_return), .ret_level(ret_level), .save_state(save_state),
  .emul_mode(emul_mode), .core_reset(core_reset));
`default_nettype wire

// ===== tb/tsec_top_tb.sv
// self-checking bench for the two-stage event controller
`timescale 1ns/10ps
`default_nettype none
`include "tsec_defs.vh"

module tsec_top_tb;
  // ----------
  // signals
  // ----------
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, slow;
  logic        core_idle, evt_valid, evt_accept, evt_return, save_state;
  logic        emul_mode, core_reset, wake_out, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, d, pw, ret_addr, evt_pc, periph_irq;
  logic [31:0] interrupt_assignment_regs [4];            // bench copy of the assignment words
  logic [6:0]  ev;                 // emu, rst, nmi pin, exc, hw err, timer, watchdog
  logic [3:0]  evt_level, ret_level, l;
  logic [3:0]  tq [$];             // levels taken, in order
  logic [3:0]  hi [3] = '{4'h3, 4'h5, 4'h6};
  logic [7:0]  ra [12] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h28, 8'h30, 8'h34};
  logic [31:0] rv [12] = '{32'h0000000F, 32'h0, 32'h0, 32'h0, 32'h0, `TSEC_IAR0_RST, `TSEC_IAR1_RST,
                           `TSEC_IAR2_RST, `TSEC_IAR3_RST, 32'h1, 32'h0, 32'h0};
  int          failures = 0, total_checks = 0, cyc = 0, lat, i, k, n;

  tsec_top i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .periph_irq(periph_irq), .emu_req(ev[0]), .rst_req(ev[1]), .nmi_pin(ev[2]),
    .exc_req(ev[3]), .hwerr_req(ev[4]), .ctimer_req(ev[5]), .wdog_nmi(ev[6]),
    .core_idle(core_idle), .evt_valid(evt_valid), .evt_level(evt_level), .evt_accept(evt_accept),
    .evt_pc(evt_pc), .evt_return(evt_return), .ret_level(ret_level), .ret_addr(ret_addr),
    .save_state(save_state), .emul_mode(emul_mode), .core_reset(core_reset),
    .wake_out(wake_out), .irq(irq));
  tsec_seq_model i_seq (.pclk(pclk), .presetn(presetn), .evt_valid(evt_valid),
    .evt_level(evt_level), .slow(slow), .evt_accept(evt_accept), .evt_pc(evt_pc));

  // clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // take log and hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (evt_valid === 1'b1 && evt_accept === 1'b1) tq.push_back(evt_level);
    if (cyc == 20000) begin
      failures++;
      print_verdict;
    end
  end

  // ----------
  // tasks
  // ----------
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask

  // one apb transfer; ends at a falling edge so flags have settled
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    d = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask

  // wait for the next take and compare its level
  task take(input logic [3:0] e);
    lat = 0;
    while (tq.size() == 0 && lat < 300) begin
      @(negedge pclk);
      lat++;
    end
    chk("taken level", {28'h0, e}, tq.size() > 0 ? {28'h0, tq.pop_front()} : 32'hFFFFFFFF);
    chk("state save", 32'h1, {31'h0, save_state});
  endtask

  // return from an event and compare the stored address
  task ret(input logic [3:0] e);
    @(posedge pclk);
    evt_return <= 1'b1;
    ret_level <= e;
    @(posedge pclk);
    evt_return <= 1'b0;
    @(negedge pclk);
    chk("return address", i_seq.mem[e], ret_addr);
  endtask

  // hold event sources high long enough for the synchronisers
  task pulse(input logic [6:0] m);
    @(posedge pclk);
    ev <= m;
    repeat (6) @(posedge pclk);
    ev <= 7'h0;
  endtask

  task print_verdict;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ----------
  // tests
  // ----------
  initial begin
    {psel, penable, pwrite, core_idle, evt_return, slow, presetn} = 7'h0;
    {paddr, pwdata, periph_irq, ev, ret_level} = '0;
    interrupt_assignment_regs = '{`TSEC_IAR0_RST, `TSEC_IAR1_RST, `TSEC_IAR2_RST, `TSEC_IAR3_RST};
    void'($urandom(32'h98D4CA53));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ra[j]) begin
      apb(1'b0, ra[j], 32'h0);
      chk("reset value", rv[j], d);
    end
    apb(1'b0, 8'h38, 32'h0);
    chk("unmapped data", 32'h0, d);
    chk("unmapped error", 32'h1, {31'h0, err});
    $display("test reset values done");
    // nesting and priority with a stalling sequencer
    slow <= 1'b1;
    apb(1'b1, `TSEC_OFF_CMASK, 32'hFFFF);
    apb(1'b1, `TSEC_OFF_SWRAISE, 32'hFF80);
    take(4'h7);
    pulse(7'h38);
    foreach (hi[j]) begin
      take(hi[j]);
      ret(hi[j]);
    end
    ret(4'h7);
    for (i = 8; i < 16; i++) begin
      take(i[3:0]);
      ret(i[3:0]);
    end
    slow <= 1'b0;
    $display("test priority done");
    // emulation outranks reset
    pulse(7'h03);
    take(`TSEC_LVL_EMU);
    chk("emulation mode", 32'h1, {31'h0, emul_mode});
    ret(`TSEC_LVL_EMU);
    chk("emulation mode", 32'h0, {31'h0, emul_mode});
    take(`TSEC_LVL_RST);
    chk("core reset", 32'h1, {31'h0, core_reset});
    ret(`TSEC_LVL_RST);
    // nmi from pin then watchdog, with the interrupt output
    apb(1'b1, `TSEC_OFF_CORE_MASK_BITS, 32'h2);
    for (k = 0; k < 2; k++) begin
      pulse(k ? 7'h40 : 7'h04);
      take(`TSEC_LVL_NMI);
      apb(1'b0, `TSEC_OFF_ISTAT, 32'h0);
      chk("nmi status", 32'h2, d & 32'h2);
      chk("irq raised", 32'h1, {31'h0, irq});
      apb(1'b1, `TSEC_OFF_CORE_MASK_BITS, 32'h0);
      chk("irq masked", 32'h0, {31'h0, irq});
      apb(1'b1, `TSEC_OFF_CORE_MASK_BITS, 32'h2);
      apb(1'b1, `TSEC_OFF_ISTAT, 32'h2);
      chk("irq cleared", 32'h0, {31'h0, irq});
      ret(`TSEC_LVL_NMI);
    end
    $display("test emulation reset nmi done");
    // peripheral routing, default then rewritten mapping
    apb(1'b1, `TSEC_OFF_PMASK, 32'hFFFFFFFF);
    pw = $urandom;
    apb(1'b1, `TSEC_OFF_PWAKE, pw);
    for (k = 0; k < 8; k++) begin
      if (k == 4) for (i = 0; i < 4; i++) begin
        for (n = 0; n < 8; n++) interrupt_assignment_regs[i][4 * n +: 4] = 4'($urandom % 9);
        apb(1'b1, `TSEC_OFF_IAR0 + 8'(4 * i), interrupt_assignment_regs[i]);
      end
      n = k == 0 ? 0 : k == 7 ? 31 : int'($urandom % 32);
      l = 4'h7 + interrupt_assignment_regs[n / 8][4 * (n % 8) +: 4];
      @(posedge pclk);
      core_idle <= k[0];
      periph_irq[n] <= 1'b1;
      take(l);
      chk("latency", 32'h1, {31'h0, lat >= 3});
      chk("wakeup", {31'h0, k[0] & pw[n]}, {31'h0, wake_out});
      apb(1'b0, `TSEC_OFF_PSTAT, 32'h0);
      chk("peripheral status", 32'h1 << n, d);
      @(posedge pclk);
      periph_irq[n] <= 1'b0;
      core_idle <= 1'b0;
      ret(l);
    end
    $display("test routing done");
    // core mask holds a latched level back
    apb(1'b1, `TSEC_OFF_CMASK, 32'h000F);
    apb(1'b1, `TSEC_OFF_SWRAISE, 32'h200);
    repeat (20) @(negedge pclk);
    chk("masked offer", 32'h0, tq.size());
    apb(1'b0, `TSEC_OFF_LATCH, 32'h0);
    chk("latched while masked", 32'h200, d);
    apb(1'b1, `TSEC_OFF_LATCH, 32'h200);
    apb(1'b0, `TSEC_OFF_LATCH, 32'h0);
    chk("latch cleared", 32'h0, d);
    apb(1'b1, `TSEC_OFF_CTRL, 32'h0);
    apb(1'b1, `TSEC_OFF_SWRAISE, 32'h200);
    apb(1'b1, `TSEC_OFF_CMASK, 32'hFFFF);
    repeat (20) @(negedge pclk);
    chk("disabled offer", 32'h0, tq.size());
    apb(1'b1, `TSEC_OFF_CTRL, 32'h1);
    take(4'h9);
    apb(1'b0, `TSEC_OFF_PEND, 32'h0);
    chk("pending", 32'h200, d);
    apb(1'b0, `TSEC_OFF_LATCH, 32'h0);
    chk("latch after take", 32'h0, d);
    ret(4'h9);
    $display("test core mask done");
    print_verdict;
  end
endmodule
`default_nettype wire
